//--- mitc_core.sv
// Instruction sequencer and data path of a small 8-bit core.
// Assumes program memory answers combinationally within one cycle and data memory
// reads combinationally and writes on the clock edge while the write enable is high.
`timescale 1ns/1ps

module mitc_core #(
  parameter int PROG_ADDR_WIDTH = mitc_pkg::PROG_ADDR_WIDTH,
  parameter int PROG_WORD_WIDTH = mitc_pkg::PROG_WORD_WIDTH,
  parameter int STACK_DEPTH = mitc_pkg::STACK_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  output logic [PROG_ADDR_WIDTH-1:0] prog_addr,
  input wire logic [PROG_WORD_WIDTH-1:0] prog_data,
  output mitc_pkg::mitc_data_req_type data_req,
  input wire logic [7:0] data_rdata,
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic carry_flag,
  output logic power_down,
  output logic instr_cycle_start
);

  localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  mitc_pkg::mitc_phase_type phase;
  logic [15:0] ir;
  logic [PROG_ADDR_WIDTH-1:0] pc;
  logic [7:0] operand;
  logic table_pending;
  logic [7:0] table_dest;
  logic [PROG_ADDR_WIDTH-1:0] stack [STACK_DEPTH];
  logic [SPW-1:0] sp;

  mitc_pkg::mitc_opcode_type opc;
  logic [2:0] sel;
  logic [7:0] k;
  logic [7:0] bit_mask;
  logic [8:0] sum;
  logic [7:0] res;
  logic wr_mem;
  logic wr_acc;
  logic upd_z;
  logic upd_c;
  logic next_c;
  logic skip;
  logic jump;
  logic [PROG_ADDR_WIDTH-1:0] target;
  logic push;
  logic pop;
  logic halt;
  logic table_read;
  logic execute;
  logic end_of_cycle;
  logic [PROG_ADDR_WIDTH-1:0] table_addr;
  logic [SPW-1:0] sp_top;

  assign opc = mitc_pkg::mitc_opcode_type'(ir[mitc_pkg::OPC_MSB:mitc_pkg::OPC_LSB]);
  assign sel = ir[mitc_pkg::SEL_MSB:mitc_pkg::SEL_LSB];
  assign k = ir[7:0];
  assign bit_mask = 8'h01 << sel;
  assign execute = !power_down && !table_pending;
  assign end_of_cycle = (phase == mitc_pkg::PH_WRITE);
  assign instr_cycle_start = (phase == mitc_pkg::PH_ADDR);
  assign table_addr = {pc[PROG_ADDR_WIDTH-1:8], accumulator};
  assign sp_top = sp - SPW'(1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= mitc_pkg::PH_ADDR;
    end else begin
      unique case (phase)
        mitc_pkg::PH_ADDR: phase <= mitc_pkg::PH_READ;
        mitc_pkg::PH_READ: phase <= mitc_pkg::PH_EXEC;
        mitc_pkg::PH_EXEC: phase <= mitc_pkg::PH_WRITE;
        mitc_pkg::PH_WRITE: phase <= mitc_pkg::PH_ADDR;
      endcase
    end
  end

  // The operand is held from the read phase so the result is stable before the write.
  always_comb begin
    res = 8'h00;
    sum = 9'h000;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    next_c = carry_flag;
    skip = 1'b0;
    jump = 1'b0;
    target = pc;
    push = 1'b0;
    pop = 1'b0;
    halt = 1'b0;
    table_read = 1'b0;
    case (opc)
      mitc_pkg::OP_MOV_A_M: begin
        res = operand;
        wr_acc = 1'b1;
      end
      mitc_pkg::OP_MOV_M_A: begin
        res = accumulator;
        wr_mem = 1'b1;
      end
      mitc_pkg::OP_MOV_A_X: begin
        res = k;
        wr_acc = 1'b1;
      end
      mitc_pkg::OP_ADD_A_M, mitc_pkg::OP_ADD_M_A, mitc_pkg::OP_ADD_A_X, mitc_pkg::OP_ADC_A_M: begin
        sum = {1'b0, accumulator} + {1'b0, (opc == mitc_pkg::OP_ADD_A_X) ? k : operand}
          + {8'h00, (opc == mitc_pkg::OP_ADC_A_M) && carry_flag};
        res = sum[7:0];
        next_c = sum[8];
        upd_c = 1'b1;
        upd_z = 1'b1;
        wr_acc = (opc != mitc_pkg::OP_ADD_M_A);
        wr_mem = (opc == mitc_pkg::OP_ADD_M_A);
      end
      mitc_pkg::OP_SUB_A_M, mitc_pkg::OP_SUB_A_X, mitc_pkg::OP_SBC_A_M: begin
        sum = {1'b0, accumulator} + {1'b0, ~((opc == mitc_pkg::OP_SUB_A_X) ? k : operand)}
          + {8'h00, (opc == mitc_pkg::OP_SBC_A_M) ? carry_flag : 1'b1};
        res = sum[7:0];
        next_c = sum[8];
        upd_c = 1'b1;
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      mitc_pkg::OP_AND_A_M, mitc_pkg::OP_AND_A_X: begin
        res = accumulator & ((opc == mitc_pkg::OP_AND_A_X) ? k : operand);
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      mitc_pkg::OP_OR_A_M, mitc_pkg::OP_OR_A_X: begin
        res = accumulator | ((opc == mitc_pkg::OP_OR_A_X) ? k : operand);
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      mitc_pkg::OP_XOR_A_M, mitc_pkg::OP_XOR_A_X: begin
        res = accumulator ^ ((opc == mitc_pkg::OP_XOR_A_X) ? k : operand);
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      mitc_pkg::OP_COMPLEMENT, mitc_pkg::OP_COMPLEMENT_TO_ACC: begin
        res = ~operand;
        upd_z = 1'b1;
        wr_mem = (opc == mitc_pkg::OP_COMPLEMENT);
        wr_acc = (opc == mitc_pkg::OP_COMPLEMENT_TO_ACC);
      end
      mitc_pkg::OP_INC_M, mitc_pkg::OP_INCREMENT_TO_ACCUMULATOR: begin
        res = operand + 8'h01;
        upd_z = 1'b1;
        wr_mem = (opc == mitc_pkg::OP_INC_M);
        wr_acc = (opc == mitc_pkg::OP_INCREMENT_TO_ACCUMULATOR);
      end
      mitc_pkg::OP_DEC_M, mitc_pkg::OP_DECREMENT_TO_ACCUMULATOR: begin
        res = operand - 8'h01;
        upd_z = 1'b1;
        wr_mem = (opc == mitc_pkg::OP_DEC_M);
        wr_acc = (opc == mitc_pkg::OP_DECREMENT_TO_ACCUMULATOR);
      end
      mitc_pkg::OP_ROTATE: begin
        case (sel[1:0])
          mitc_pkg::ROT_RIGHT: res = {operand[0], operand[7:1]};
          mitc_pkg::ROT_LEFT: res = {operand[6:0], operand[7]};
          mitc_pkg::ROT_RIGHT_THROUGH_CARRY: res = {carry_flag, operand[7:1]};
          default: res = {operand[6:0], carry_flag};
        endcase
        upd_c = sel[1];
        next_c = sel[0] ? operand[7] : operand[0];
        wr_acc = sel[2];
        wr_mem = !sel[2];
      end
      mitc_pkg::OP_BIT_CLEAR: begin
        res = operand & ~bit_mask;
        wr_mem = 1'b1;
      end
      mitc_pkg::OP_BIT_SET: begin
        res = operand | bit_mask;
        wr_mem = 1'b1;
      end
      mitc_pkg::OP_SKIP_BIT_ZERO: skip = ((operand & bit_mask) == 8'h00);
      mitc_pkg::OP_SKIP_BIT_ONE: skip = ((operand & bit_mask) != 8'h00);
      mitc_pkg::OP_UNCONDITIONAL_JUMP: begin
        jump = 1'b1;
        target = ir[PROG_ADDR_WIDTH-1:0];
      end
      mitc_pkg::OP_CALL: begin
        jump = 1'b1;
        push = 1'b1;
        target = ir[PROG_ADDR_WIDTH-1:0];
      end
      mitc_pkg::OP_RETURN: begin
        jump = 1'b1;
        pop = 1'b1;
        target = stack[sp_top];
      end
      mitc_pkg::OP_MISC: begin
        case (sel)
          mitc_pkg::MISC_HALT: halt = 1'b1;
          mitc_pkg::MISC_TABLE_READ: table_read = 1'b1;
          mitc_pkg::MISC_INTERRUPT_RETURN: begin
            jump = 1'b1;
            pop = 1'b1;
            target = stack[sp_top];
          end
          mitc_pkg::MISC_SKIP_ZERO: skip = (operand == 8'h00);
          default: res = 8'h00;
        endcase
      end
      default: res = 8'h00;
    endcase
    if (wr_mem && k == mitc_pkg::PROGRAM_COUNTER_LOW_BYTE_ADDR) begin
      jump = 1'b1;
      target = {pc[PROG_ADDR_WIDTH-1:8], res};
    end
  end

  // Data memory port; the write strobe covers the last phase only.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_req <= '0;
      operand <= 8'h00;
    end else begin
      unique case (phase)
        mitc_pkg::PH_ADDR: data_req.addr <= table_pending ? table_dest : k;
        mitc_pkg::PH_READ: operand <= data_rdata;
        mitc_pkg::PH_EXEC: begin
          data_req.we <= !power_down && (table_pending || wr_mem);
          data_req.wdata <= table_pending ? prog_data[7:0] : res;
        end
        mitc_pkg::PH_WRITE: data_req.we <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ir <= mitc_pkg::RST_IR;
      pc <= '0;
      prog_addr <= '0;
      table_pending <= 1'b0;
      table_dest <= 8'h00;
    end else if (end_of_cycle && !power_down) begin
      if (table_pending) begin
        table_pending <= 1'b0;
        prog_addr <= pc;
      end else if (jump) begin
        ir <= mitc_pkg::NOP_WORD;
        pc <= target;
        prog_addr <= target;
      end else begin
        ir <= skip ? mitc_pkg::NOP_WORD : prog_data[15:0];
        pc <= pc + PROG_ADDR_WIDTH'(1);
        prog_addr <= table_read ? table_addr : pc + PROG_ADDR_WIDTH'(1);
        table_pending <= table_read;
        table_dest <= k;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sp <= '0;
    end else if (end_of_cycle && execute) begin
      if (push) begin
        stack[sp] <= pc;
        sp <= (sp == SPW'(STACK_DEPTH - 1)) ? '0 : sp + SPW'(1);
      end else if (pop) begin
        sp <= (sp == '0) ? SPW'(STACK_DEPTH - 1) : sp_top;
      end
    end
  end

  // Accumulator and flags change only at the end of an executing cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      accumulator <= mitc_pkg::RST_ACC;
      zero_flag <= mitc_pkg::RST_FLAG;
      carry_flag <= mitc_pkg::RST_FLAG;
    end else if (end_of_cycle && execute) begin
      if (wr_acc) begin
        accumulator <= res;
      end
      if (upd_z) begin
        zero_flag <= (res == 8'h00);
      end
      if (upd_c) begin
        carry_flag <= next_c;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      power_down <= 1'b0;
    end else if (end_of_cycle && execute && halt) begin
      power_down <= 1'b1;
    end
  end

endmodule

//--- mitc_pkg.sv
// Shared constants and types for the instruction timing core.
// Assumes one clock domain; the core, memory model, checker and bench all use these names.
package mitc_pkg;

  // System clock cycles that make one instruction cycle.
  localparam int SYS_PER_INSTR = 4;
  localparam int CLOCK_PERIOD_NS = 100;

  // Default widths and depths.
  localparam int PROG_ADDR_WIDTH = 11;
  localparam int PROG_WORD_WIDTH = 16;
  localparam int STACK_DEPTH = 6;

  // Data memory location whose writes also load the program counter low byte.
  localparam logic [7:0] PROGRAM_COUNTER_LOW_BYTE_ADDR = 8'h06;

  // Values after reset.
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [15:0] RST_IR = 16'h0000;
  localparam logic RST_FLAG = 1'b0;

  // Instruction word fields: [15:11] opcode, [10:8] selector, [7:0] operand.
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 11;
  localparam int SEL_MSB = 10;
  localparam int SEL_LSB = 8;
  localparam logic [15:0] NOP_WORD = 16'h0000;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_MOV_A_M = 5'h01, OP_MOV_M_A = 5'h02, OP_MOV_A_X = 5'h03,
    OP_ADD_A_M = 5'h04, OP_ADD_M_A = 5'h05, OP_ADD_A_X = 5'h06, OP_ADC_A_M = 5'h07,
    OP_SUB_A_M = 5'h08, OP_SUB_A_X = 5'h09, OP_SBC_A_M = 5'h0A, OP_AND_A_M = 5'h0B,
    OP_OR_A_M = 5'h0C, OP_XOR_A_M = 5'h0D, OP_AND_A_X = 5'h0E, OP_OR_A_X = 5'h0F,
    OP_XOR_A_X = 5'h10, OP_COMPLEMENT = 5'h11, OP_COMPLEMENT_TO_ACC = 5'h12, OP_INC_M = 5'h13,
    OP_INCREMENT_TO_ACCUMULATOR = 5'h14, OP_DEC_M = 5'h15, OP_DECREMENT_TO_ACCUMULATOR = 5'h16,
    OP_ROTATE = 5'h17, OP_BIT_CLEAR = 5'h18, OP_BIT_SET = 5'h19, OP_SKIP_BIT_ZERO = 5'h1A,
    OP_SKIP_BIT_ONE = 5'h1B, OP_UNCONDITIONAL_JUMP = 5'h1C, OP_CALL = 5'h1D, OP_RETURN = 5'h1E,
    OP_MISC = 5'h1F
  } mitc_opcode_type;

  // Selector values of the miscellaneous group.
  localparam logic [2:0] MISC_HALT = 3'h0;
  localparam logic [2:0] MISC_TABLE_READ = 3'h1;
  localparam logic [2:0] MISC_INTERRUPT_RETURN = 3'h2;
  localparam logic [2:0] MISC_SKIP_ZERO = 3'h3;

  // Rotate selector: bit 2 sends the result to the accumulator.
  localparam logic [1:0] ROT_RIGHT = 2'h0;
  localparam logic [1:0] ROT_LEFT = 2'h1;
  localparam logic [1:0] ROT_RIGHT_THROUGH_CARRY = 2'h2;
  localparam logic [1:0] ROT_LEFT_THROUGH_CARRY = 2'h3;

  // Phases of one instruction cycle.
  typedef enum logic [3:0] {
    PH_ADDR = 4'b0001,
    PH_READ = 4'b0010,
    PH_EXEC = 4'b0100,
    PH_WRITE = 4'b1000
  } mitc_phase_type;

  // Data memory request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } mitc_data_req_type;

endpackage

//--- mitc_mem.sv
// Program and data memory model facing the core.
// Assumes the bench preloads both arrays by hierarchical access.
`timescale 1ns/1ps
module mitc_mem (
  input wire logic clock,
  input wire logic [10:0] prog_addr,
  output logic [15:0] prog_data,
  input wire mitc_pkg::mitc_data_req_type data_req,
  output logic [7:0] data_rdata
);
  logic [15:0] prog [0:2047];
  logic [7:0] dmem [0:255];
  assign prog_data = prog[prog_addr];
  assign data_rdata = dmem[data_req.addr];
  always @(posedge clock) begin
    if (data_req.we === 1'b1) begin
      dmem[data_req.addr] <= data_req.wdata;
    end
  end
endmodule

//--- mitc_checker.sv
// Port timing checks for the core.
// Assumes one clock and the core's active-low reset.
`timescale 1ns/1ps
module mitc_checker #(
  parameter int PROG_ADDR_WIDTH = 11
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [PROG_ADDR_WIDTH-1:0] prog_addr,
  input wire mitc_pkg::mitc_data_req_type data_req,
  input wire logic [7:0] accumulator,
  input wire logic power_down,
  input wire logic instr_cycle_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // The phase counter keeps running in power-down, so the period must hold there as well.
  phase_period_a: assert property (
    instr_cycle_start |=> !instr_cycle_start [*3] ##1 instr_cycle_start) else $error("cycle not four clocks");
  fetch_hold_a: assert property (!instr_cycle_start |-> $stable(prog_addr))
    else $error("program address moved mid-cycle");
  data_addr_hold_a: assert property ($changed(data_req.addr) |-> $past(instr_cycle_start))
    else $error("data address moved late");
  write_pulse_a: assert property (data_req.we |=> !data_req.we)
    else $error("write longer than one clock");
  write_phase_a: assert property (data_req.we |-> $past(instr_cycle_start, 3))
    else $error("write outside last phase");
  write_addr_a: assert property (data_req.we |-> $stable(data_req.addr))
    else $error("write address differs from read");
  sleep_freeze_a: assert property (power_down |=> power_down && $stable(prog_addr) && $stable(accumulator))
    else $error("core moved in power-down");
  sleep_quiet_a: assert property (power_down |-> !data_req.we)
    else $error("write in power-down");
  cover property ($rose(power_down));
  cover property (data_req.we && data_req.addr == 8'h06);
  cover property (instr_cycle_start && $changed(prog_addr));
endmodule
bind mitc_core mitc_checker #(.PROG_ADDR_WIDTH(PROG_ADDR_WIDTH)) chk_u (.clock(clock), .nrst(nrst),
  .prog_addr(prog_addr), .data_req(data_req), .accumulator(accumulator), .power_down(power_down),
  .instr_cycle_start(instr_cycle_start));

//--- mcu_instruction_timing_core_tb.sv
// Self-checking bench: runs short programs, checks results and cycle counts.
// Assumes the memory model is preloaded while reset is held.
`timescale 1ns/1ps
module mcu_instruction_timing_core_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [10:0] prog_addr;
  logic [15:0] prog_data;
  mitc_pkg::mitc_data_req_type data_req;
  logic [7:0] data_rdata, accumulator, a, m;
  logic zero_flag, carry_flag, power_down, instr_cycle_start;
  logic [2:0] b;
  logic [10:0] e;
  logic [15:0] tv;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  mitc_core dut_u (.clock(clock), .nrst(nrst), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_req(data_req), .data_rdata(data_rdata), .accumulator(accumulator), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .power_down(power_down), .instr_cycle_start(instr_cycle_start));
  mitc_mem mem_u (.clock(clock), .prog_addr(prog_addr), .prog_data(prog_data), .data_req(data_req),
    .data_rdata(data_rdata));
  always @(posedge clock) begin
    if (!nrst) begin
      cycles <= 0;
    end else if (instr_cycle_start === 1'b1 && power_down === 1'b0) begin
      cycles <= cycles + 1;
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Returns to-memory, carry, zero and result; carry starts clear.
  function automatic logic [10:0] model(input logic [4:0] op, input logic [2:0] s, input logic [7:0] a,
    input logic [7:0] m);
    logic [8:0] t;
    logic c;
    t = 9'h000;
    c = 1'b0;
    case (op)
      5'h01, 5'h03: t = 9'(m);
      5'h02: t = 9'(a);
      5'h04, 5'h05, 5'h06, 5'h07: t = a + m;
      5'h08, 5'h09: t = a - m;
      5'h0A: t = a - m - 9'h001;
      5'h0B, 5'h0E: t = 9'(a & m);
      5'h0C, 5'h0F: t = 9'(a | m);
      5'h0D, 5'h10: t = 9'(a ^ m);
      5'h11, 5'h12: t = 9'(~m);
      5'h13, 5'h14: t = 9'(m + 8'h01);
      5'h15, 5'h16: t = 9'(m - 8'h01);
      5'h17: begin
        case (s[1:0])
          2'h0: t[7:0] = {m[0], m[7:1]};
          2'h1: t[7:0] = {m[6:0], m[7]};
          2'h2: {t[7:0], c} = {1'b0, m};
          default: {c, t[7:0]} = {m, 1'b0};
        endcase
      end
      5'h18: t = 9'(m & ~(8'h01 << s));
      default: t = 9'(m | (8'h01 << s));
    endcase
    if (op inside {[5'h04:5'h07]}) c = t[8];
    if (op inside {[5'h08:5'h0A]}) c = ~t[8];
    return {op inside {5'h02, 5'h05, 5'h11, 5'h13, 5'h15, 5'h18, 5'h19} || (op == 5'h17 && !s[2]), c,
      op inside {[5'h04:5'h16]} && t[7:0] == 8'h00, t[7:0]};
  endfunction
  task automatic clear();
    nrst = 1'b0;
    for (int i = 0; i < 2048; i++) mem_u.prog[i] = 16'h0000;
    for (int i = 0; i < 256; i++) mem_u.dmem[i] = 8'($urandom);
  endtask
  task automatic run(input string name, input int exp_cyc);
    int i;
    repeat (16) @(negedge clock);
    chk("reset", 32'h00000001, {prog_addr, data_req, power_down, zero_flag, carry_flag, instr_cycle_start});
    chk("reset acc", 32'h00000000, accumulator);
    nrst = 1'b1;
    for (i = 0; i < 500; i++) begin
      @(negedge clock);
      if (power_down === 1'b1) break;
    end
    if (i == 500) begin
      n_errors++;
      $display("[ERR] %s halt expected 1 seen 0", name);
      end_sim();
    end
    repeat (12) @(negedge clock);
    chk("cycles", exp_cyc, cycles);
    $display("test %s done", name);
  endtask
  initial begin
    void'($urandom(71));
    for (int op = 1; op <= 25; op++) begin
      for (int j = 0; j < 4; j++) begin
        clear();
        a = (j == 0) ? 8'hFF : (j == 1) ? 8'h00 : 8'($urandom);
        m = (j < 2) ? 8'h01 : 8'($urandom);
        b = (op == 23) ? {1'($urandom), 2'(j)} : 3'($urandom);
        mem_u.dmem[8'h20] = m;
        mem_u.prog[0] = {5'h03, 3'h0, a};
        mem_u.prog[1] = {5'(op), b, (op inside {3, 6, 9, 14, 15, 16}) ? m : 8'h20};
        mem_u.prog[2] = 16'hF800;
        e = model(5'(op), b, a, m);
        run("alu", 4);
        chk("acc", e[10] ? a : e[7:0], accumulator);
        chk("mem", e[10] ? e[7:0] : m, mem_u.dmem[8'h20]);
        chk("flags", e[9:8], {carry_flag, zero_flag});
      end
    end
    clear();
    b = 3'($urandom);
    mem_u.dmem[8'h21] = 8'h00;
    mem_u.dmem[8'h22] = 8'($urandom) & ~(8'h01 << b);
    mem_u.prog[0] = {5'h1D, 11'h005};
    mem_u.prog[1] = {5'h1C, 11'h008};
    mem_u.prog[5] = 16'h1811;
    mem_u.prog[6] = 16'hF000;
    mem_u.prog[8] = 16'hFB21;
    mem_u.prog[9] = 16'h18EE;
    mem_u.prog[10] = {5'h1B, b, 8'h22};
    mem_u.prog[11] = {5'h1A, b, 8'h22};
    mem_u.prog[12] = 16'h18EE;
    mem_u.prog[13] = 16'h3001;
    mem_u.prog[14] = 16'h1006;
    mem_u.prog[15] = 16'h18EE;
    mem_u.prog[18] = 16'hF800;
    run("flow", 17);
    chk("flow acc", 32'h00000012, accumulator);
    chk("low byte mem", 32'h00000012, mem_u.dmem[8'h06]);
    clear();
    tv = 16'($urandom);
    mem_u.prog[11'h030] = tv;
    mem_u.prog[0] = 16'h1830;
    mem_u.prog[1] = 16'hF923;
    mem_u.prog[2] = 16'hF800;
    run("table", 5);
    chk("table", tv[7:0], mem_u.dmem[8'h23]);
    clear();
    mem_u.prog[0] = {5'h1D, 11'h004};
    mem_u.prog[1] = 16'h3001;
    mem_u.prog[2] = 16'hF800;
    mem_u.prog[4] = 16'h1822;
    mem_u.prog[5] = 16'hFA00;
    run("return", 8);
    chk("return acc", 32'h00000023, accumulator);
    end_sim();
  end
endmodule
